// file: design/mfm_pkg.sv
// Constants, register map and fault code table of the motor fault manager
// Functional notes
// R01: Every abnormality belongs to exactly one class: alarm, warning or travel limit.
// R02: Any active abnormality turns the power indicator orange and shows its code.
// R03: Any alarm opens drive ready, forces servo off and engages the dynamic brake.
// R04: Emergency stop clears on input release; other alarms hold until power removal.
// R05: Alarms A0..P9 force servo off, touch no warning or limit output, ignore clear.
// R06: History records all alarms except E0 and F4; C4, E2 only when backup allowed.
// R07: Warnings open the warning output, keep drive ready, brake on servo-off kinds.
// R08: A warning clears on fault clear input or command once its cause is gone.
// R09: A3 C0 F1 P5 servo off, A5 no change, C5 F5 F8 cycle stop, all recorded.
// R10: F5 or F8 during motion stops the motor only after the current move ends.
// R11: Entering a travel limit opens its output and allows only moves back out.
// R12: A travel limit clears by itself once the motor leaves the forbidden area.
// R13: Exit counts whether by positioning, jog or manual rotation with servo off.
// R14: F2 software and F3 hardware limits open limit outputs and are never recorded.
// R15: The segment display shows fault codes only in indicator fault mode.
// R16: History holds 32 records; a further record drops the oldest, appends newest.
// R17: Each abnormality is latched on its own so all can be reported together.
`default_nettype none
package mfm_pkg;
  // APB register byte offsets
  localparam logic [7:0] MFM_OFS_CTRL = 8'h00;
  localparam logic [7:0] MFM_OFS_CMD = 8'h04;
  localparam logic [7:0] MFM_OFS_ALARM = 8'h08;
  localparam logic [7:0] MFM_OFS_WARN = 8'h0C;
  localparam logic [7:0] MFM_OFS_LIMIT = 8'h10;
  localparam logic [7:0] MFM_OFS_SNAP = 8'h14;
  localparam logic [7:0] MFM_OFS_HCNT = 8'h18;
  localparam logic [7:0] MFM_OFS_HIDX = 8'h1C;
  localparam logic [7:0] MFM_OFS_HDATA = 8'h20;
  localparam logic [7:0] MFM_OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] MFM_OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] MFM_OFS_DISP = 8'h2C;
  // Field positions
  localparam int MFM_CTRL_FAULT_MODE = 0;
  localparam int MFM_CTRL_BACKUP_OK = 1;
  localparam int MFM_CMD_CLEAR = 0;
  localparam int MFM_CMD_REPORT = 1;
  localparam int MFM_IRQ_ALARM = 0;
  localparam int MFM_IRQ_WARN = 1;
  localparam int MFM_IRQ_LIMIT = 2;
  localparam int MFM_IRQ_DROP = 3;
  // Reset values
  localparam logic [1:0] MFM_CTRL_RST = 2'h1;
  localparam logic [3:0] MFM_IRQ_MASK_RST = 4'h0;
  // Sizes
  localparam int MFM_N_ALARM = 19;
  localparam int MFM_N_WARN = 8;
  localparam int MFM_N_FAULT = 29;
  localparam int MFM_HIST_DEPTH = 32;
  localparam logic [5:0] MFM_HIST_FULL = 6'h20;
  localparam int MFM_N_SYNC = 33;
  // Alarm indices with special handling
  localparam int MFM_AL_C4 = 7;
  localparam int MFM_AL_E0 = 8;
  localparam int MFM_AL_E2 = 9;
  localparam int MFM_AL_ESTOP = 13;
  // Warning behaviour masks, bit order A3 A5 C0 C5 F1 F5 F8 P5
  localparam logic [7:0] MFM_WARN_SERVO_OFF = 8'h95;
  localparam logic [7:0] MFM_WARN_CYCLE_NOW = 8'h08;
  localparam logic [7:0] MFM_WARN_CYCLE_END = 8'h60;
  // Alarms always recorded, C4 and E2 added when backup is allowed
  localparam logic [18:0] MFM_AL_REC_BASE = 19'h7DC7F;
  localparam logic [18:0] MFM_AL_REC_BACKUP = 19'h00280;
  // Two character codes, alarms 0..18, warnings 19..26, limits F2 and F3
  localparam logic [15:0] MFM_CODE [0:28] = '{
    16'h4130, 16'h4131, 16'h4132, 16'h4134, 16'h4137, 16'h4139,
    16'h4333, 16'h4334, 16'h4530, 16'h4532, 16'h4537, 16'h4538, 16'h4539,
    16'h4634, 16'h5030, 16'h5031, 16'h5032, 16'h5033, 16'h5039,
    16'h4133, 16'h4135, 16'h4330, 16'h4335, 16'h4631, 16'h4635, 16'h4638, 16'h5035,
    16'h4632, 16'h4633};
endpackage
`default_nettype wire

// file: design/mfm_sync.sv
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module mfm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: design/mfm_main.sv
// Motor fault manager: fault latches, motor actions, display, history, APB
`default_nettype none
module mfm_main
  import mfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [17:0] alarm_cause_in,
  input wire logic emergency_stop_in,
  input wire logic fault_clear_in,
  input wire logic [7:0] warn_cause_in,
  input wire logic [3:0] limit_area_in,
  input wire logic motor_moving_in,
  output logic drive_ready_out,
  output logic warning_out,
  output logic travel_limit_plus_out,
  output logic travel_limit_minus_out,
  output logic travel_limit_minus_alt_out,
  output logic move_plus_allow_out,
  output logic move_minus_allow_out,
  output logic servo_off_out,
  output logic dyn_brake_out,
  output logic cycle_stop_out,
  output logic power_led_orange_out,
  output logic [15:0] seg_code_out,
  output logic irq_out
);
  import mfm_pkg::*;

  logic [MFM_N_SYNC-1:0] sync_s;
  logic [17:0] alarm_cause_s;
  logic estop_s;
  logic fclr_s;
  logic [7:0] warn_cause_s;
  logic [3:0] limit_s;
  logic moving_s;
  logic fclr_d_r;

  logic [1:0] ctrl_r;
  logic [MFM_N_ALARM-1:0] alarm_r;
  logic [MFM_N_WARN-1:0] warn_r;
  logic [3:0] limit_r;
  logic [MFM_N_FAULT-1:0] snap_r;
  logic [26:0] pend_r;
  logic [15:0] hist_mem_r [0:MFM_HIST_DEPTH-1];
  logic [4:0] hist_wp_r;
  logic [5:0] hist_cnt_r;
  logic [4:0] hist_idx_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;

  logic [MFM_N_ALARM-1:0] alarm_det;
  logic [MFM_N_ALARM-1:0] alarm_nxt;
  logic [MFM_N_WARN-1:0] warn_nxt;
  logic [MFM_N_ALARM-1:0] alarm_rec;
  logic [26:0] pend_new;
  logic [26:0] pend_pick;
  logic pend_any;
  logic [4:0] pend_idx;
  logic [MFM_N_FAULT-1:0] active;
  logic [4:0] disp_idx;
  logic disp_any;
  logic [15:0] seg_nxt;
  logic [3:0] irq_set;
  logic clear_req;
  logic setup_ph;
  logic wr_en;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [4:0] hist_ra;
  logic servo_off_nxt;
  logic plus_in_limit;
  logic minus_in_limit;

  // Pins come from outside the clock domain
  mfm_sync #(.W(MFM_N_SYNC)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({motor_moving_in, limit_area_in, warn_cause_in, fault_clear_in,
        emergency_stop_in, alarm_cause_in}),
    .q(sync_s)
  );

  assign alarm_cause_s = sync_s[17:0];
  assign estop_s = sync_s[18];
  assign fclr_s = sync_s[19];
  assign warn_cause_s = sync_s[27:20];
  assign limit_s = sync_s[31:28];
  assign moving_s = sync_s[32];

  // APB handshake: data prepared in setup, completed in first access cycle
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  // Fault clear by rising edge of the input or the command write
  assign clear_req = (fclr_s & ~fclr_d_r) | (wr_en && paddr == MFM_OFS_CMD &&
                     pwdata[MFM_CMD_CLEAR]); // R08

  // Emergency stop occupies its own slot among the alarms
  assign alarm_det = {alarm_cause_s[17:13], estop_s, alarm_cause_s[12:0]}; // R01

  // Only a power cycle frees a latched alarm; the stop slot follows its pin
  always_comb begin
    alarm_nxt = alarm_r | alarm_det; // R04 R05 R17
    alarm_nxt[MFM_AL_ESTOP] = estop_s; // R04
  end

  // Set wins over clear, and a warning whose cause stays cannot be cleared
  assign warn_nxt = (warn_r | warn_cause_s) & ~({MFM_N_WARN{clear_req}} &
                    ~warn_cause_s); // R08 R17

  // Starts low like the idle pin, so reset release makes no false clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fclr_d_r <= 1'b0;
    end else begin
      fclr_d_r <= fclr_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_r <= '0;
      warn_r <= '0;
      limit_r <= '0;
    end else begin
      alarm_r <= alarm_nxt;
      warn_r <= warn_nxt;
      limit_r <= limit_s; // R12 R13
    end
  end

  assign active = {limit_r[3] | limit_r[2], limit_r[1] | limit_r[0], warn_r, alarm_r};

  // Limit slots: 0 soft plus, 1 soft minus, 2 hard plus, 3 hard minus
  assign plus_in_limit = limit_r[0] | limit_r[2];
  assign minus_in_limit = limit_r[1] | limit_r[3];

  assign servo_off_nxt = (|alarm_r) | (|(warn_r & MFM_WARN_SERVO_OFF)); // R03 R09

  // Motor actions and open-for-fault outputs, closed reads as one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_ready_out <= 1'b0;
      warning_out <= 1'b1;
      travel_limit_plus_out <= 1'b1;
      travel_limit_minus_out <= 1'b1;
      travel_limit_minus_alt_out <= 1'b1;
      move_plus_allow_out <= 1'b1;
      move_minus_allow_out <= 1'b1;
      servo_off_out <= 1'b1;
      dyn_brake_out <= 1'b1;
      cycle_stop_out <= 1'b0;
      power_led_orange_out <= 1'b0;
    end else begin
      drive_ready_out <= ~(|alarm_r); // R03 R05 R07
      warning_out <= ~(|warn_r); // R07
      travel_limit_plus_out <= ~plus_in_limit; // R11 R14
      travel_limit_minus_out <= ~minus_in_limit; // R11 R14
      travel_limit_minus_alt_out <= ~minus_in_limit; // R14
      move_plus_allow_out <= ~plus_in_limit; // R11
      move_minus_allow_out <= ~minus_in_limit; // R11
      servo_off_out <= servo_off_nxt; // R03 R09
      dyn_brake_out <= servo_off_nxt; // R03 R07
      // For F5 and F8 a move in progress is allowed to finish first
      cycle_stop_out <= (|(warn_r & MFM_WARN_CYCLE_NOW)) |
                        ((|(warn_r & MFM_WARN_CYCLE_END)) & ~moving_s); // R09 R10
      power_led_orange_out <= |active; // R02
    end
  end

  // Lowest active slot wins the display
  // Fixed priority, so a later warning never hides an alarm
  always_comb begin
    disp_idx = 5'h00;
    disp_any = 1'b0;
    for (int i = MFM_N_FAULT - 1; i >= 0; i--) begin
      if (active[i]) begin
        disp_idx = 5'(i);
        disp_any = 1'b1;
      end
    end
  end

  always_comb begin
    if (ctrl_r[MFM_CTRL_FAULT_MODE]) begin
      seg_nxt = disp_any ? MFM_CODE[disp_idx] : 16'h0000; // R02 R15
    end else begin
      seg_nxt = {9'h000, estop_s, fclr_s, moving_s, limit_s}; // R15
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_code_out <= 16'h0000;
    end else begin
      seg_code_out <= seg_nxt;
    end
  end

  // Which newly raised faults go to history
  assign alarm_rec = MFM_AL_REC_BASE |
                     (ctrl_r[MFM_CTRL_BACKUP_OK] ? MFM_AL_REC_BACKUP : 19'h00000); // R06
  assign pend_new = {warn_nxt & ~warn_r, alarm_nxt & ~alarm_r & alarm_rec}; // R06 R09 R14

  // One record per cycle keeps the write port single
  always_comb begin
    pend_idx = 5'h00;
    pend_any = 1'b0;
    pend_pick = '0;
    for (int i = 26; i >= 0; i--) begin
      if (pend_r[i]) begin
        pend_idx = 5'(i);
        pend_any = 1'b1;
      end
    end
    if (pend_any) begin
      pend_pick[pend_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~pend_pick) | pend_new;
    end
  end

  // Records are lost on reset; there is no backup store behind them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_wp_r <= 5'h00;
      hist_cnt_r <= 6'h00;
      for (int i = 0; i < MFM_HIST_DEPTH; i++) begin
        hist_mem_r[i] <= 16'h0000;
      end
    end else if (pend_any) begin
      // Ring overwrite drops the oldest record when full
      hist_mem_r[hist_wp_r] <= MFM_CODE[pend_idx]; // R16
      hist_wp_r <= hist_wp_r + 5'h01; // R16
      if (hist_cnt_r != MFM_HIST_FULL) begin
        hist_cnt_r <= hist_cnt_r + 6'h01; // R16
      end
    end
  end

  // Index zero names the latest record
  assign hist_ra = hist_wp_r - 5'h01 - hist_idx_r;

  // Status snapshot for the report command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      snap_r <= '0;
    end else if (wr_en && paddr == MFM_OFS_CMD && pwdata[MFM_CMD_REPORT]) begin
      snap_r <= active; // R17
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= MFM_CTRL_RST;
      hist_idx_r <= 5'h00;
      irq_mask_r <= MFM_IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        MFM_OFS_CTRL: ctrl_r <= pwdata[1:0];
        MFM_OFS_HIDX: hist_idx_r <= pwdata[4:0];
        MFM_OFS_IRQ_MASK: irq_mask_r <= pwdata[3:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Sticky events; a new event beats a simultaneous write-one clear
  assign irq_set = {pend_any && hist_cnt_r == MFM_HIST_FULL,
                    |(limit_s & ~limit_r),
                    |(warn_nxt & ~warn_r),
                    |(alarm_nxt & ~alarm_r)};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= 4'h0;
    end else if (wr_en && paddr == MFM_OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  // Registered so a status write never glitches the pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      MFM_OFS_CTRL: rd_val[1:0] = ctrl_r;
      MFM_OFS_CMD: rd_val = 32'h0000_0000;
      MFM_OFS_ALARM: rd_val[MFM_N_ALARM-1:0] = alarm_r; // R17
      MFM_OFS_WARN: rd_val[MFM_N_WARN-1:0] = warn_r; // R17
      MFM_OFS_LIMIT: rd_val[3:0] = limit_r; // R17
      MFM_OFS_SNAP: rd_val[MFM_N_FAULT-1:0] = snap_r;
      MFM_OFS_HCNT: rd_val[5:0] = hist_cnt_r;
      MFM_OFS_HIDX: rd_val[4:0] = hist_idx_r;
      MFM_OFS_HDATA: rd_val[15:0] = hist_mem_r[hist_ra];
      MFM_OFS_IRQ_STAT: rd_val[3:0] = irq_stat_r;
      MFM_OFS_IRQ_MASK: rd_val[3:0] = irq_mask_r;
      MFM_OFS_DISP: rd_val[15:0] = seg_code_out;
      default: rd_hit = 1'b0;
    endcase
  end

  // One wait-free access cycle after setup
  // Unmapped addresses still answer, flagged by pslverr
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~rd_hit;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/mfm_monitor.sv
// Port checker of the motor fault manager, bound to its top module
`default_nettype none
module mfm_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic emergency_stop_in,
  input wire logic [17:0] alarm_cause_in,
  input wire logic [7:0] warn_cause_in,
  input wire logic [3:0] limit_area_in,
  input wire logic drive_ready_out,
  input wire logic warning_out,
  input wire logic travel_limit_plus_out,
  input wire logic travel_limit_minus_out,
  input wire logic travel_limit_minus_alt_out,
  input wire logic move_plus_allow_out,
  input wire logic servo_off_out,
  input wire logic dyn_brake_out,
  input wire logic cycle_stop_out,
  input wire logic power_led_orange_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] live_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Outputs lag reset release by one edge, so the first edges are skipped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) live_r <= 2'h0;
    else live_r <= {live_r[0], 1'b1};
  end
  chk_alarm_servo_off: assert property (!drive_ready_out |-> servo_off_out && dyn_brake_out)
    else $error("ready open without servo off and brake");
  chk_alarm_opens_ready: assert property ($rose(emergency_stop_in) || $rose(|alarm_cause_in)
    |-> ##4 !drive_ready_out)
    else $error("alarm did not open ready in four edges");
  chk_minus_alias_same: assert property (travel_limit_minus_out == travel_limit_minus_alt_out)
    else $error("minus limit outputs differ");
  chk_fault_shows_orange: assert property (live_r[1] && (!drive_ready_out || !warning_out
    || !travel_limit_plus_out || !travel_limit_minus_out) |-> power_led_orange_out)
    else $error("fault active but indicator not orange");
  chk_limit_enter_opens: assert property ($rose(limit_area_in[0])
    |-> ##4 !travel_limit_plus_out && !move_plus_allow_out)
    else $error("plus limit entry not reported");
  chk_limit_leave_clears: assert property ($fell(limit_area_in[0]) && !limit_area_in[2]
    |-> ##4 travel_limit_plus_out)
    else $error("plus limit not cleared on exit");
  chk_warn_keeps_ready: assert property ($rose(warn_cause_in[1]) && drive_ready_out
    |-> ##4 !warning_out && drive_ready_out)
    else $error("warning output or ready wrong");
  chk_cycle_stop_now: assert property ($rose(warn_cause_in[3]) |-> ##4 cycle_stop_out)
    else $error("cycle stop not raised");
  chk_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  cover property ($fell(drive_ready_out));
  cover property ($fell(warning_out));
  cover property ($fell(travel_limit_minus_out));
endmodule
bind mfm_main mfm_monitor u_mon (.clk, .rst_b, .psel, .penable, .pready, .pslverr,
  .emergency_stop_in, .alarm_cause_in, .warn_cause_in, .limit_area_in, .drive_ready_out,
  .warning_out, .travel_limit_plus_out, .travel_limit_minus_out, .travel_limit_minus_alt_out,
  .move_plus_allow_out, .servo_off_out, .dyn_brake_out, .cycle_stop_out, .power_led_orange_out);
`default_nettype wire

// file: sim/mfm_host.sv
// Host controller model driving the stop and clear pins
`default_nettype none
module mfm_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic estop_req,
  input wire logic clear_req,
  output logic emergency_stop_in,
  output logic fault_clear_in
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) emergency_stop_in <= 1'b0;
    else emergency_stop_in <= estop_req;
  end
  // Clear acts on a rising edge, so a one cycle request is enough
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) fault_clear_in <= 1'b0;
    else fault_clear_in <= clear_req;
  end
endmodule
`default_nettype wire

// file: sim/mfm_main_tb_top.sv
// Self-checking bench of the motor fault manager
`default_nettype none
module mfm_main_tb_top;
  import mfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, warn_cause_in;
  logic [31:0] pwdata, prdata, q;
  logic [17:0] alarm_cause_in;
  logic [3:0] limit_area_in;
  logic motor_moving_in, estop_req, clear_req, emergency_stop_in, fault_clear_in;
  logic drive_ready_out, warning_out, travel_limit_plus_out, travel_limit_minus_out;
  logic travel_limit_minus_alt_out, move_plus_allow_out, move_minus_allow_out;
  logic servo_off_out, dyn_brake_out, cycle_stop_out, power_led_orange_out, irq_out;
  logic [15:0] seg_code_out;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  mfm_main dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .alarm_cause_in, .emergency_stop_in, .fault_clear_in, .warn_cause_in,
    .limit_area_in, .motor_moving_in, .drive_ready_out, .warning_out, .travel_limit_plus_out,
    .travel_limit_minus_out, .travel_limit_minus_alt_out, .move_plus_allow_out,
    .move_minus_allow_out, .servo_off_out, .dyn_brake_out, .cycle_stop_out,
    .power_led_orange_out, .seg_code_out, .irq_out);
  mfm_host u_host (.clk, .rst_b, .estop_req, .clear_req, .emergency_stop_in, .fault_clear_in);
  always #50 clk = ~clk;
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Wait for pready with no assumed latency; the cycle limit ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, q, x);
  endtask
  // Pin to output takes four edges; six leaves margin
  task automatic settle();
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_clr();
    @(posedge clk);
    clear_req <= 1'b1;
    @(posedge clk);
    clear_req <= 1'b0;
    settle();
  endtask
  initial begin
    clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    alarm_cause_in = 0; warn_cause_in = 0; limit_area_in = 0; motor_moving_in = 0;
    estop_req = 0; clear_req = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdc("ctrl", MFM_OFS_CTRL, 32'h1);
    rdc("mask", MFM_OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {e, q[30:0]}, 32'h80000000);
    wr(MFM_OFS_IRQ_MASK, 32'h2);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      motor_moving_in <= 1'b1;
      warn_cause_in <= 8'h1 << i;
      settle();
      chk("warn", {warning_out, drive_ready_out, power_led_orange_out}, 3'h3);
      chk("servo", servo_off_out, MFM_WARN_SERVO_OFF[i]);
      chk("brake", dyn_brake_out, MFM_WARN_SERVO_OFF[i]);
      chk("cstop", cycle_stop_out, MFM_WARN_CYCLE_NOW[i]);
      chk("seg", seg_code_out, MFM_CODE[19 + i]);
      chk("irq", irq_out, 1'b1);
      @(posedge clk);
      motor_moving_in <= 1'b0;
      settle();
      chk("cstop_end", cycle_stop_out, MFM_WARN_CYCLE_NOW[i] | MFM_WARN_CYCLE_END[i]);
      pulse_clr();
      chk("held", warning_out, 1'b0);
      @(posedge clk);
      warn_cause_in <= 8'h0;
      settle();
      if (i[0]) pulse_clr();
      else wr(MFM_OFS_CMD, 32'h1);
      settle();
      chk("cleared", warning_out, 1'b1);
    end
    rdc("hcnt", MFM_OFS_HCNT, 32'h8);
    rdc("latest", MFM_OFS_HDATA, {16'h0, MFM_CODE[26]});
    for (int i = 0; i < 25; i++) begin
      @(posedge clk);
      warn_cause_in <= 8'h2;
      settle();
      @(posedge clk);
      warn_cause_in <= 8'h0;
      settle();
      wr(MFM_OFS_CMD, 32'h1);
    end
    rdc("hfull", MFM_OFS_HCNT, 32'h20);
    rdc("drop", MFM_OFS_IRQ_STAT, 32'hA);
    wr(MFM_OFS_IRQ_STAT, 32'hF);
    settle();
    chk("irq_clr", irq_out, 1'b0);
    @(posedge clk);
    limit_area_in <= 4'h1;
    settle();
    chk("soft", {travel_limit_plus_out, travel_limit_minus_out, move_plus_allow_out,
      move_minus_allow_out, drive_ready_out, warning_out}, 6'h17);
    chk("seg_f2", seg_code_out, MFM_CODE[27]);
    @(posedge clk);
    limit_area_in <= 4'h8;
    settle();
    chk("hard", {travel_limit_plus_out, travel_limit_minus_out, travel_limit_minus_alt_out,
      move_plus_allow_out, move_minus_allow_out}, 5'h12);
    chk("seg_f3", seg_code_out, MFM_CODE[28]);
    wr(MFM_OFS_CTRL, 32'h0);
    settle();
    chk("seg_io", seg_code_out, 16'h0008);
    wr(MFM_OFS_CTRL, 32'h1);
    @(posedge clk);
    limit_area_in <= 4'h0;
    settle();
    chk("lim_off", {travel_limit_plus_out, travel_limit_minus_out}, 2'h3);
    rdc("lim_nohist", MFM_OFS_HDATA, {16'h0, MFM_CODE[20]});
    @(posedge clk);
    estop_req <= 1'b1;
    settle();
    chk("estop", {drive_ready_out, servo_off_out, dyn_brake_out}, 3'h3);
    chk("seg_f4", seg_code_out, MFM_CODE[13]);
    rdc("estop_nohist", MFM_OFS_HDATA, {16'h0, MFM_CODE[20]});
    @(posedge clk);
    estop_req <= 1'b0;
    settle();
    chk("estop_off", drive_ready_out, 1'b1);
    @(posedge clk);
    alarm_cause_in <= 18'h180;
    settle();
    rdc("e0_c4", MFM_OFS_HDATA, {16'h0, MFM_CODE[20]});
    wr(MFM_OFS_CTRL, 32'h3);
    @(posedge clk);
    alarm_cause_in <= 18'h380;
    settle();
    rdc("e2", MFM_OFS_HDATA, {16'h0, MFM_CODE[9]});
    @(posedge clk);
    alarm_cause_in <= 18'h381;
    settle();
    chk("alarm", {drive_ready_out, warning_out, travel_limit_plus_out, servo_off_out}, 4'h7);
    chk("seg_a0", seg_code_out, MFM_CODE[0]);
    rdc("a0", MFM_OFS_HDATA, {16'h0, MFM_CODE[0]});
    @(posedge clk);
    alarm_cause_in <= 18'h0;
    pulse_clr();
    wr(MFM_OFS_CMD, 32'h1);
    settle();
    chk("latched", drive_ready_out, 1'b0);
    rdc("alarms", MFM_OFS_ALARM, 32'h381);
    @(posedge clk);
    limit_area_in <= 4'h2;
    settle();
    wr(MFM_OFS_CMD, 32'h2);
    rdc("snap", MFM_OFS_SNAP, 32'h0800_0381);
    rdc("disp", MFM_OFS_DISP, {16'h0, MFM_CODE[0]});
    wr(MFM_OFS_HIDX, 32'h1);
    rdc("older", MFM_OFS_HDATA, {16'h0, MFM_CODE[9]});
    // Power removal is the only way out of a latched alarm
    @(posedge clk);
    limit_area_in <= 4'h0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("power_cycle", {drive_ready_out, servo_off_out}, 2'h2);
    rdc("alarms_gone", MFM_OFS_ALARM, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
